// ### fac_regs.svh
/*
 Constants for the fault address capture block: system encodings, classes, upper-half values.
 Assumes inclusion by the design module and its checker only.
*/
// What this block does
// - Abort and PC alignment classes taken to top level load fault address register.
// - Top-level fault address register is one 64-bit field.
// - Without top level implemented, register absent and accesses are undefined.
// - External abort under top-byte-ignore may leave upper eight bits unknown.
// - Non-walk external abort address valid only when address-not-valid flag is 0.
// - Other classes taken to top level may leave contents unknown.
// - Cache-instruction faults record the instruction's register operand address.
// - 32-bit origin zeros upper half, or 0x00000001 on wrapped increment.
// - Tagged data aborts and watchpoints keep tag bits in the address.
// - Lower-level execution may leave top-level register unknown.
// - With capabilities, captured address is post-relocation.
// - Multi-access capability faults record lowest address of the accesses.
// - Record lowest faulting address; no priority among differing faults.
// - Exception return from top level may leave the register unknown.
// - No reset initialisation of top-level register.
// - Top-level register decoded at 11/110/0110/0000/000 for read and write.
// - Kernel register writes decoded at 11/000/0110/0000/000.
// - EL1 kernel write traps 0x18: capability first, then virtual-memory write trap.
// - EL2 kernel-name access: capability trap, else host extension selects hypervisor.
// - EL3 kernel access traps 0x18 on capability denial, else completes.
// - EL0 access to these registers is undefined.
// - EL1 kernel read traps to EL2 when read trapping set, after capability check.
`ifndef FAC_REGS_SVH
`define FAC_REGS_SVH
`define FAC_OP0_SYS 2'h3
`define FAC_OP1_TOP 3'h6
`define FAC_OP1_KERN 3'h0
`define FAC_OP1_HYP 3'h4
`define FAC_CRN_FAR 4'h6
`define FAC_CRM_FAR 4'h0
`define FAC_OP2_FAR 3'h0
`define FAC_EC_IABT_LO 6'h20
`define FAC_EC_IABT_CUR 6'h21
`define FAC_EC_PCALIGN 6'h22
`define FAC_EC_DABT_LO 6'h24
`define FAC_EC_DABT_CUR 6'h25
`define FAC_EC_SYSTRAP 6'h18
`define FAC_HI_WRAP 32'h0000_0001
`define FAC_HI_ZERO 32'h0000_0000
`endif

// ### fac_pkg.sv
/*
 Types for the fault address capture block.
 Assumes fac_regs.svh is on the include path.
*/
package fac_pkg;
   typedef enum logic [1:0] {FAC_EL0, FAC_EL1, FAC_EL2, FAC_EL3} fac_level_t;
   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } fac_sysenc_t;
   typedef struct packed {
      logic valid;
      logic [5:0] ec;
      logic [63:0] vaddr;
      logic from_32bit;
      logic wrap_bit32;
   } fac_capture_t;
   typedef struct packed {
      logic undef;
      logic trap;
      fac_level_t trap_level;
      logic [5:0] trap_ec;
   } fac_outcome_t;
endpackage : fac_pkg

// ### fac_fault_address_capture.sv
/*
 Fault address capture and system access decode for the top-level and kernel registers.
 Assumes the exception-entry logic presents a relocated, lowest, tagged address and
 that the hypervisor register and capability permission arrive on the core clock.
*/
`timescale 1ns/10ps
`include "fac_regs.svh"
module fac_fault_address_capture #(
   parameter bit TOP_LEVEL_IMPL = 1'b1,
   parameter bit CAP_EXT_IMPL = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Exception entry to top level
   input wire fac_pkg::fac_capture_t capture_i,
   // System register access
   input wire logic sys_valid_i,
   input wire logic sys_write_i,
   input wire fac_pkg::fac_sysenc_t sys_enc_i,
   input wire logic [63:0] sys_wdata_i,
   // Processor state and controls
   input wire fac_pkg::fac_level_t current_privilege_level_i,
   input wire logic capability_sysreg_permission_i,
   input wire fac_pkg::fac_level_t capability_trap_target_level_i,
   input wire logic halted_i,
   input wire logic el2_enabled_64_i,
   input wire logic trap_vm_control_writes_i,
   input wire logic trap_vm_control_reads_i,
   input wire logic host_extension_enable_i,
   // Results
   output logic sys_done_o,
   output fac_pkg::fac_outcome_t sys_outcome_o,
   output logic [63:0] sys_rdata_o,
   output logic [63:0] top_level_fault_address_o,
   output logic [63:0] kernel_fault_address_o,
   output logic [63:0] hypervisor_fault_address_o
);
   // Register storage; top and kernel have no reset value
   logic [63:0] top_reg, top_next;
   logic [63:0] kern_reg, kern_next;
   logic [63:0] hyp_reg, hyp_next;
   logic done_reg;
   fac_pkg::fac_outcome_t out_reg, out_next;
   logic [63:0] rdata_reg, rdata_next;

   // Encoding decode
   wire logic enc_far = sys_enc_i.op0 == `FAC_OP0_SYS && sys_enc_i.crn == `FAC_CRN_FAR
                        && sys_enc_i.crm == `FAC_CRM_FAR && sys_enc_i.op2 == `FAC_OP2_FAR;
   wire logic hit_top = sys_valid_i && enc_far && sys_enc_i.op1 == `FAC_OP1_TOP;
   wire logic hit_kern = sys_valid_i && enc_far && sys_enc_i.op1 == `FAC_OP1_KERN;
   wire logic hit_any = hit_top || hit_kern;

   // Capability denial is checked before any virtualization trap
   wire logic cap_deny = CAP_EXT_IMPL && !capability_sysreg_permission_i && !halted_i;
   wire logic at_el0 = current_privilege_level_i == fac_pkg::FAC_EL0;
   wire logic at_el1 = current_privilege_level_i == fac_pkg::FAC_EL1;
   wire logic at_el2 = current_privilege_level_i == fac_pkg::FAC_EL2;
   wire logic at_el3 = current_privilege_level_i == fac_pkg::FAC_EL3;
   wire logic vm_trap = el2_enabled_64_i
                        && (sys_write_i ? trap_vm_control_writes_i : trap_vm_control_reads_i);
   // EL2 cannot route a capability trap to EL1; anything but EL2 goes to EL3
   wire fac_pkg::fac_level_t cap_tgt_el2 =
      (capability_trap_target_level_i == fac_pkg::FAC_EL2) ? fac_pkg::FAC_EL2 : fac_pkg::FAC_EL3;

   // Classes that load the top-level register
   wire logic ec_loads = capture_i.ec == `FAC_EC_IABT_LO || capture_i.ec == `FAC_EC_IABT_CUR
                         || capture_i.ec == `FAC_EC_PCALIGN || capture_i.ec == `FAC_EC_DABT_LO
                         || capture_i.ec == `FAC_EC_DABT_CUR;
   // Upper half for a capture from 32-bit state
   wire logic [31:0] hi_32 = capture_i.wrap_bit32 ? `FAC_HI_WRAP : `FAC_HI_ZERO;
   // Address is already relocated, tagged and lowest; stored verbatim from 64-bit origin
   wire logic [63:0] cap_addr = capture_i.from_32bit ? {hi_32, capture_i.vaddr[31:0]}
                                                      : capture_i.vaddr;
   wire logic cap_load = TOP_LEVEL_IMPL && capture_i.valid && ec_loads;

   // Access decision and register update
   always_comb begin
      out_next = '0;
      rdata_next = '0;
      top_next = top_reg;
      kern_next = kern_reg;
      hyp_next = hyp_reg;
      // Other classes leave the register alone, an allowed unknown value
      if (cap_load) begin
         top_next = cap_addr;
      end
      if (hit_any && at_el0) begin
         out_next.undef = 1'b1;
      end else if (hit_top) begin
         if (!TOP_LEVEL_IMPL || !at_el3) begin
            out_next.undef = 1'b1;
         end else if (cap_deny) begin
            out_next.trap = 1'b1;
            out_next.trap_level = fac_pkg::FAC_EL3;
            out_next.trap_ec = `FAC_EC_SYSTRAP;
         end else if (sys_write_i) begin
            top_next = sys_wdata_i; // Software write overrides a same-cycle capture
         end else begin
            rdata_next = top_reg;
         end
      end else if (hit_kern) begin
         if (cap_deny) begin
            out_next.trap = 1'b1;
            out_next.trap_ec = `FAC_EC_SYSTRAP;
            if (at_el1) begin
               out_next.trap_level = capability_trap_target_level_i;
            end else if (at_el2) begin
               out_next.trap_level = cap_tgt_el2;
            end else begin
               out_next.trap_level = fac_pkg::FAC_EL3;
            end
         end else if (at_el1 && vm_trap) begin
            out_next.trap = 1'b1;
            out_next.trap_level = fac_pkg::FAC_EL2;
            out_next.trap_ec = `FAC_EC_SYSTRAP;
         end else if (at_el2 && host_extension_enable_i) begin
            if (sys_write_i) begin
               hyp_next = sys_wdata_i;
            end else begin
               rdata_next = hyp_reg;
            end
         end else if (sys_write_i) begin
            kern_next = sys_wdata_i;
         end else begin
            rdata_next = kern_reg;
         end
      end
   end

   // Storage; data registers skip reset on purpose
   always_ff @(posedge clk_i) begin
      top_reg <= top_next;
      kern_reg <= kern_next;
      hyp_reg <= hyp_next;
      rdata_reg <= rdata_next;
   end

   // Handshake and outcome are reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         done_reg <= 1'b0;
         out_reg <= '0;
      end else begin
         done_reg <= hit_any;
         out_reg <= out_next;
      end
   end

   // Capture lands one edge after entry, before any handler read can be decoded
   assign sys_done_o = done_reg;
   assign sys_outcome_o = out_reg;
   assign sys_rdata_o = rdata_reg;
   assign top_level_fault_address_o = top_reg;
   assign kernel_fault_address_o = kern_reg;
   assign hypervisor_fault_address_o = hyp_reg;
endmodule : fac_fault_address_capture

// ### fac_properties.sv
/* Checker for the fault address block outputs.
 Assumes it is bound to the top module with its default parameters. */
`timescale 1ns/10ps
`include "fac_regs.svh"
module fac_properties #(parameter bit CAP_EXT_IMPL = 1'b1) (
   // Watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire fac_pkg::fac_capture_t capture_i,
   input wire logic sys_valid_i,
   input wire logic sys_write_i,
   input wire fac_pkg::fac_sysenc_t sys_enc_i,
   input wire fac_pkg::fac_level_t current_privilege_level_i,
   input wire logic capability_sysreg_permission_i,
   input wire fac_pkg::fac_level_t capability_trap_target_level_i,
   input wire logic halted_i,
   input wire logic sys_done_o,
   input wire fac_pkg::fac_outcome_t sys_outcome_o,
   input wire logic [63:0] top_level_fault_address_o
);
   // Decode of the two watched encodings and the capture qualifier
   wire base = sys_enc_i.op0 == `FAC_OP0_SYS && sys_enc_i.crn == `FAC_CRN_FAR
      && sys_enc_i.crm == `FAC_CRM_FAR && sys_enc_i.op2 == `FAC_OP2_FAR;
   wire t = sys_enc_i.op1 == `FAC_OP1_TOP;
   wire k = sys_enc_i.op1 == `FAC_OP1_KERN;
   wire hit = sys_valid_i && base && (t || k);
   wire den = CAP_EXT_IMPL && !capability_sysreg_permission_i && !halted_i;
   wire fac_pkg::fac_level_t lv = current_privilege_level_i;
   // A same-cycle software write of the top register wins, so it is left out
   wire cap = capture_i.valid && !(hit && t && sys_write_i)
      && capture_i.ec inside {`FAC_EC_IABT_LO, `FAC_EC_IABT_CUR, `FAC_EC_PCALIGN,
         `FAC_EC_DABT_LO, `FAC_EC_DABT_CUR};
   logic [63:0] cap_addr_reg;
   // Expected capture value, upper half forced for 32-bit origin
   always_ff @(posedge clk_i) begin
      cap_addr_reg <= {capture_i.from_32bit ? {31'h0, capture_i.wrap_bit32}
         : capture_i.vaddr[63:32], capture_i.vaddr[31:0]};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   AST_DONE: assert property (hit |=> sys_done_o) else $error("no done");
   AST_NODONE: assert property (!hit |=> !sys_done_o) else $error("stray done");
   AST_EL0: assert property (hit && lv == fac_pkg::FAC_EL0 |=> sys_outcome_o.undef)
      else $error("el0 access defined");
   AST_TOPLO: assert property (hit && t && lv != fac_pkg::FAC_EL3 |=> sys_outcome_o.undef)
      else $error("low top access defined");
   AST_PASS: assert property (hit && t && lv == fac_pkg::FAC_EL3 && !den
      |=> !sys_outcome_o.trap && !sys_outcome_o.undef) else $error("top access refused");
   AST_CAP3: assert property (hit && k && lv == fac_pkg::FAC_EL3 && den |=>
      sys_outcome_o == {2'h1, fac_pkg::FAC_EL3, `FAC_EC_SYSTRAP}) else $error("el3 trap wrong");
   AST_CAP1: assert property (hit && k && lv == fac_pkg::FAC_EL1 && den |=>
      sys_outcome_o == {2'h1, $past(capability_trap_target_level_i), `FAC_EC_SYSTRAP})
      else $error("el1 trap wrong");
   AST_CAPT: assert property (cap |=> top_level_fault_address_o == cap_addr_reg)
      else $error("capture wrong");
   // Main scenarios reached
   cover property (cap);
   cover property (hit && den);
   cover property (hit && k && !sys_write_i);
endmodule : fac_properties
bind fac_fault_address_capture fac_properties #(.CAP_EXT_IMPL(CAP_EXT_IMPL)) fac_properties_i (.*);

// ### tb.sv
/* Self-checking bench: random accesses and captures against a reference.
 Assumes the design keeps its default parameters. */
`timescale 1ns/10ps
module tb;
   // Stimulus, outputs and reference state
   logic clk_i = 0, resetn_i = 0, sys_valid_i = 0, sys_write_i = 0, halted_i = 0, sys_done_o;
   logic capability_sysreg_permission_i = 1, el2_enabled_64_i = 0, host_extension_enable_i = 0;
   logic trap_vm_control_writes_i = 0, trap_vm_control_reads_i = 0;
   fac_pkg::fac_capture_t capture_i = '0;
   fac_pkg::fac_sysenc_t sys_enc_i = '0;
   fac_pkg::fac_level_t current_privilege_level_i = fac_pkg::FAC_EL3;
   fac_pkg::fac_level_t capability_trap_target_level_i = fac_pkg::FAC_EL1;
   fac_pkg::fac_outcome_t sys_outcome_o;
   logic [63:0] sys_wdata_i = '0, sys_rdata_o, m_top, m_kern, m_hyp;
   logic [63:0] top_level_fault_address_o, kernel_fault_address_o, hypervisor_fault_address_o;
   // Note: known flag, outcome, read data, then top, kernel and hypervisor contents
   logic [266:0] q[$];
   logic [266:0] n;
   logic [5:0] ecs[7] = '{6'h20, 6'h21, 6'h22, 6'h24, 6'h25, 6'h18, 6'h3C};
   int error_cnt = 0, compares = 0, cyc = 0;
   fac_fault_address_capture fac_fault_address_capture_i (.*);
   initial forever #2.5 clk_i = ~clk_i;
   task automatic check(input logic [191:0] seen, input logic [191:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic print_verdict();
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   // One access; c = level, target, permission, halt, el2, traps, host, write, top
   task automatic acc(input logic [11:0] c, input logic miss, input logic [63:0] d);
      fac_pkg::fac_outcome_t o;
      logic [63:0] r;
      fac_pkg::fac_level_t lv;
      fac_pkg::fac_level_t tg;
      @(posedge clk_i);
      #1;
      lv = fac_pkg::fac_level_t'(c[11:10]);
      tg = fac_pkg::fac_level_t'((c[9:8] == 2'h0) ? 2'h2 : c[9:8]);
      current_privilege_level_i = lv;
      capability_trap_target_level_i = tg;
      {capability_sysreg_permission_i, halted_i, el2_enabled_64_i, trap_vm_control_writes_i,
         trap_vm_control_reads_i, host_extension_enable_i, sys_write_i} = c[7:1];
      sys_enc_i = {2'h3, c[0] ? 3'h6 : 3'h0, 4'h6, {3'h0, miss}, 3'h0};
      sys_wdata_i = d;
      sys_valid_i = 1;
      capture_i.valid = 0;
      o = '0;
      r = 64'h0;
      if (lv == fac_pkg::FAC_EL0 || (c[0] && lv != fac_pkg::FAC_EL3)) o.undef = 1;
      else if (c[7:6] == 2'h0) o = {2'h1, (lv == fac_pkg::FAC_EL1) ? tg :
         (lv == fac_pkg::FAC_EL2 && tg == fac_pkg::FAC_EL2) ? tg : fac_pkg::FAC_EL3, 6'h18};
      else if (lv == fac_pkg::FAC_EL1 && c[5] && (c[1] ? c[4] : c[3]))
         o = {2'h1, fac_pkg::FAC_EL2, 6'h18};
      else if (!c[1]) r = c[0] ? m_top : (lv == fac_pkg::FAC_EL2 && c[2]) ? m_hyp : m_kern;
      else if (miss) r = 64'h0; // An unmatched encoding must not change any register
      else if (c[0]) m_top = d;
      else if (lv == fac_pkg::FAC_EL2 && c[2]) m_hyp = d;
      else m_kern = d;
      if (!miss) q.push_back({!$isunknown({m_top, m_kern, m_hyp}), o, r, m_top, m_kern, m_hyp});
   endtask : acc
   task automatic cap(input logic [5:0] ec, input logic b32, input logic wrap);
      @(posedge clk_i);
      #1;
      sys_valid_i = 0;
      capture_i = {1'b1, ec, {$urandom, $urandom}, b32, wrap};
      if (ec inside {6'h20, 6'h21, 6'h22, 6'h24, 6'h25})
         m_top = b32 ? {31'h0, wrap, capture_i.vaddr[31:0]} : capture_i.vaddr;
   endtask : cap
   // Each done takes the oldest note; the cycle counter guards against a hang
   always @(negedge clk_i) begin
      if (sys_done_o === 1'b1) begin
         if (q.size() == 0) begin
            check(192'h1, 192'h0);
         end else begin
            n = q.pop_front();
            check(192'({sys_outcome_o, sys_rdata_o}), 192'(n[265:192]));
            if (n[266]) check({top_level_fault_address_o, kernel_fault_address_o,
               hypervisor_fault_address_o}, n[191:0]);
         end
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(90674));
      repeat (8) @(posedge clk_i);
      #1 resetn_i = 1;
      acc(12'hD83, 0, {$urandom, $urandom});
      acc(12'hD82, 0, {$urandom, $urandom});
      acc(12'h986, 0, {$urandom, $urandom});
      foreach (ecs[i]) begin
         cap(ecs[i], 1'($urandom), 1'($urandom));
         acc(12'hD81, 0, 64'h0);
      end
      $display("test capture end");
      repeat (400) acc(12'($urandom), $urandom_range(7) == 0, {$urandom, $urandom});
      @(posedge clk_i);
      #1 sys_valid_i = 0;
      repeat (4) @(posedge clk_i);
      check(192'(q.size()), 192'h0);
      $display("test random end");
      print_verdict();
   end
endmodule : tb
